// ### hw/sequence_automask_tagging_control.sv
// Purpose : Sequence auto-mask, transition timeout and tagging control register bank
// Assumes : Register requests come from the serial interface logic on core_clk_i
// Notes   : Sequence logging and order comparison live outside; this bank feeds them
//
// How it works
// - Power-active fall masks power-off selected channels
// - Sleep rise masks sleep-exit selected channels
// - Sleep fall masks sleep-entry selected channels
// - Mask bit N-1 governs channel N
// - Timeout expiry releases every active auto-mask
// - Sixteen-bit timeout, value plus one milliseconds
// - Range reaches seconds; low byte covers 256 ms
// - Tag pulse 50 us plus 10 us per step
// - Up tagging bit selects off or UV threshold
// - Up threshold select resets to 0x1F
// - Down tagging select likewise, resets to zero
// - Expected power-on order values for channels 1 and 2 only
// - Power-active rise masks power-on selected channels
// - Edge direction names the transition kind
`timescale 1ns/1ps
module sequence_automask_tagging_control #(
  parameter int unsigned MS_CYCLES = seq_ctl_pkg::MS_CYCLES_DEF   // Cycles per millisecond
) (
  input  wire logic                  core_clk_i,                 // Core clock
  input  wire logic                  sys_rst_i,                  // Synchronous reset, active high
  input  wire seq_ctl_pkg::reg_req_t reg_req_i,                  // Register request
  output logic [7:0]                 reg_rdata_o,                // Read data
  output logic                       reg_ack_o,                  // One-cycle answer to a request
  input  wire logic                  power_active_input_i,       // Power-active pin
  input  wire logic                  sleep_input_i,              // Sleep pin
  input  wire logic                  tag_request_i,              // Start one sync tagging pulse
  output logic [7:0]                 irq_automask_o,             // Per-channel fault interrupt mask
  output logic                       timeout_busy_o,             // Auto-mask window running
  output logic                       sync_tag_pulse_o,           // Sync tagging pulse
  output logic [7:0]                 tag_use_uv_threshold_o,     // 1 = UV threshold, 0 = off threshold
  output logic [7:0]                 expected_power_on_order_ch1_o, // Expected order, channel 1
  output logic [7:0]                 expected_power_on_order_ch2_o  // Expected order, channel 2
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Pulse length in microseconds for a width code
  function automatic logic [seq_ctl_pkg::TAG_US_W-1:0] tag_width_us(input logic [7:0] code);
    tag_width_us = seq_ctl_pkg::TAG_US_W'(seq_ctl_pkg::TAG_BASE_US)
                 + seq_ctl_pkg::TAG_US_W'(code) * seq_ctl_pkg::TAG_US_W'(seq_ctl_pkg::TAG_STEP_US);
  endfunction

  // Terminal count of a prescaler of the given period
  function automatic logic [seq_ctl_pkg::MS_PRE_W-1:0] term_of(input int unsigned period);
    term_of = seq_ctl_pkg::MS_PRE_W'(period - 1);
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic act_rise, act_fall;     // Power-active edges
  logic slp_rise, slp_fall;     // Sleep edges

  sync_edge_detect u_act_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pin_i      (power_active_input_i),
    .level_o    (),
    .rise_o     (act_rise),
    .fall_o     (act_fall)
  );

  sync_edge_detect u_slp_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pin_i      (sleep_input_i),
    .level_o    (),
    .rise_o     (slp_rise),
    .fall_o     (slp_fall)
  );

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  seq_ctl_pkg::ctl_regs_t regs_q, regs_d;   // Software-visible control state
  logic [7:0]             rdata_q, rdata_d; // Registered read data
  logic                   ack_q, ack_d;     // Answer strobe
  logic [7:0]             mask_q;           // Active auto-mask, read back at no address
  logic                   busy_q;           // Timeout window running

  // Write decode and read mux; unmapped reads answer zero, unmapped writes drop
  always_comb begin
    regs_d  = regs_q;
    rdata_d = rdata_q;
    ack_d   = reg_req_i.write | reg_req_i.read;
    if (reg_req_i.write) begin
      unique case (reg_req_i.addr)
        seq_ctl_pkg::OFS_AUTOMASK_POWER_ON:    regs_d.automask_power_on           = reg_req_i.wdata;
        seq_ctl_pkg::OFS_AUTOMASK_POWER_OFF:   regs_d.automask_power_off          = reg_req_i.wdata;
        seq_ctl_pkg::OFS_AUTOMASK_SLEEP_EXIT:  regs_d.automask_sleep_exit         = reg_req_i.wdata;
        seq_ctl_pkg::OFS_AUTOMASK_SLEEP_ENTRY: regs_d.automask_sleep_entry        = reg_req_i.wdata;
        seq_ctl_pkg::OFS_TIMEOUT_HIGH:         regs_d.transition_timeout_high     = reg_req_i.wdata;
        seq_ctl_pkg::OFS_TIMEOUT_LOW:          regs_d.transition_timeout_low      = reg_req_i.wdata;
        seq_ctl_pkg::OFS_TAG_PULSE_WIDTH:      regs_d.tag_pulse_width             = reg_req_i.wdata;
        seq_ctl_pkg::OFS_UP_TAG_THRESHOLD:     regs_d.up_tag_threshold_select     = reg_req_i.wdata;
        seq_ctl_pkg::OFS_DOWN_TAG_THRESHOLD:   regs_d.down_tag_threshold_select   = reg_req_i.wdata;
        seq_ctl_pkg::OFS_EXPECTED_ORDER_CH1:   regs_d.expected_power_on_order_ch1 = reg_req_i.wdata;
        seq_ctl_pkg::OFS_EXPECTED_ORDER_CH2:   regs_d.expected_power_on_order_ch2 = reg_req_i.wdata;
        default: ;                                                            // Unmapped: ignored
      endcase
    end
    if (reg_req_i.read) begin
      unique case (reg_req_i.addr)
        seq_ctl_pkg::OFS_AUTOMASK_POWER_ON:    rdata_d = regs_q.automask_power_on;
        seq_ctl_pkg::OFS_AUTOMASK_POWER_OFF:   rdata_d = regs_q.automask_power_off;
        seq_ctl_pkg::OFS_AUTOMASK_SLEEP_EXIT:  rdata_d = regs_q.automask_sleep_exit;
        seq_ctl_pkg::OFS_AUTOMASK_SLEEP_ENTRY: rdata_d = regs_q.automask_sleep_entry;
        seq_ctl_pkg::OFS_TIMEOUT_HIGH:         rdata_d = regs_q.transition_timeout_high;
        seq_ctl_pkg::OFS_TIMEOUT_LOW:          rdata_d = regs_q.transition_timeout_low;
        seq_ctl_pkg::OFS_TAG_PULSE_WIDTH:      rdata_d = regs_q.tag_pulse_width;
        seq_ctl_pkg::OFS_UP_TAG_THRESHOLD:     rdata_d = regs_q.up_tag_threshold_select;
        seq_ctl_pkg::OFS_DOWN_TAG_THRESHOLD:   rdata_d = regs_q.down_tag_threshold_select;
        seq_ctl_pkg::OFS_EXPECTED_ORDER_CH1:   rdata_d = regs_q.expected_power_on_order_ch1;
        seq_ctl_pkg::OFS_EXPECTED_ORDER_CH2:   rdata_d = regs_q.expected_power_on_order_ch2;
        default:                               rdata_d = seq_ctl_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // Register storage with documented reset values
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      regs_q.automask_power_on           <= seq_ctl_pkg::RST_AUTOMASK;
      regs_q.automask_power_off          <= seq_ctl_pkg::RST_AUTOMASK;
      regs_q.automask_sleep_exit         <= seq_ctl_pkg::RST_AUTOMASK;
      regs_q.automask_sleep_entry        <= seq_ctl_pkg::RST_AUTOMASK;
      regs_q.transition_timeout_high     <= seq_ctl_pkg::RST_TIMEOUT;
      regs_q.transition_timeout_low      <= seq_ctl_pkg::RST_TIMEOUT;
      regs_q.tag_pulse_width             <= seq_ctl_pkg::RST_TAG_PULSE;
      regs_q.up_tag_threshold_select     <= seq_ctl_pkg::RST_UP_TAG_THRESH;
      regs_q.down_tag_threshold_select   <= seq_ctl_pkg::RST_DOWN_TAG_THRESH;
      regs_q.expected_power_on_order_ch1 <= seq_ctl_pkg::RST_EXPECTED_ORDER;
      regs_q.expected_power_on_order_ch2 <= seq_ctl_pkg::RST_EXPECTED_ORDER;
      rdata_q                            <= seq_ctl_pkg::RDATA_UNMAPPED;
      ack_q                              <= 1'b0;
    end else begin
      regs_q  <= regs_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Auto-mask window and transition timeout
  // ---------------------------------------------------------------------------
  typedef enum logic {MASK_IDLE, MASK_RUN} mask_state_t;

  mask_state_t                     mstate_q, mstate_d;   // Window state
  logic [7:0]                      mask_d;               // Next active mask
  logic                            busy_d;
  logic [seq_ctl_pkg::MS_PRE_W-1:0] ms_pre_q, ms_pre_d;  // Millisecond prescaler
  logic [15:0]                     ms_cnt_q, ms_cnt_d;   // Whole milliseconds elapsed
  logic [15:0]                     tout_code;            // Programmed timeout code
  logic [7:0]                      edge_mask;            // Channels chosen by this cycle's edges
  logic                            any_edge;

  // High and low bytes form one code; low byte alone spans 1..256 ms
  assign tout_code = {regs_q.transition_timeout_high, regs_q.transition_timeout_low};

  // Each edge kind picks its own register; bit N-1 is channel N
  always_comb begin
    edge_mask = 8'h00;
    if (act_rise) edge_mask = edge_mask | regs_q.automask_power_on;
    if (act_fall) edge_mask = edge_mask | regs_q.automask_power_off;
    if (slp_rise) edge_mask = edge_mask | regs_q.automask_sleep_exit;
    if (slp_fall) edge_mask = edge_mask | regs_q.automask_sleep_entry;
  end

  assign any_edge = act_rise | act_fall | slp_rise | slp_fall;

  // Window sequencing; a new edge during a window restarts the count and adds
  // its channels, so an overlapping transition never unmasks early
  always_comb begin
    mstate_d = mstate_q;
    mask_d   = mask_q;
    busy_d   = busy_q;
    ms_pre_d = ms_pre_q;
    ms_cnt_d = ms_cnt_q;
    if (any_edge) begin
      mstate_d = MASK_RUN;
      mask_d   = (mstate_q == MASK_RUN) ? (mask_q | edge_mask) : edge_mask;
      busy_d   = 1'b1;
      ms_pre_d = '0;
      ms_cnt_d = 16'h0000;
    end else begin
      unique case (mstate_q)
        MASK_IDLE: begin
          mask_d = 8'h00;
          busy_d = 1'b0;
        end
        MASK_RUN: begin
          if (ms_pre_q == term_of(MS_CYCLES)) begin
            ms_pre_d = '0;
            if (ms_cnt_q == tout_code) begin
              mstate_d = MASK_IDLE;
              mask_d   = 8'h00;
              busy_d   = 1'b0;
            end else begin
              ms_cnt_d = ms_cnt_q + 16'h0001;
            end
          end else begin
            ms_pre_d = ms_pre_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Window registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mstate_q <= MASK_IDLE;
      mask_q   <= 8'h00;
      busy_q   <= 1'b0;
      ms_pre_q <= '0;
      ms_cnt_q <= 16'h0000;
    end else begin
      mstate_q <= mstate_d;
      mask_q   <= mask_d;
      busy_q   <= busy_d;
      ms_pre_q <= ms_pre_d;
      ms_cnt_q <= ms_cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Tagging threshold direction
  // ---------------------------------------------------------------------------
  logic       dir_up_q, dir_up_d;    // Last transition was upward
  logic [7:0] thr_q, thr_d;          // Selected threshold per channel

  // Up transitions use the up select, down transitions the down select
  always_comb begin
    dir_up_d = dir_up_q;
    if (act_rise | slp_rise)      dir_up_d = 1'b1;
    else if (act_fall | slp_fall) dir_up_d = 1'b0;
    thr_d = dir_up_d ? regs_q.up_tag_threshold_select
                     : regs_q.down_tag_threshold_select;
  end

  // Direction registers; power-up starts as an upward sequence
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dir_up_q <= 1'b1;
      thr_q    <= seq_ctl_pkg::RST_UP_TAG_THRESH;
    end else begin
      dir_up_q <= dir_up_d;
      thr_q    <= thr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Sync tagging pulse
  // ---------------------------------------------------------------------------
  logic                             pulse_q, pulse_d;    // Pulse level
  logic [seq_ctl_pkg::US_CNT_W-1:0] us_pre_q, us_pre_d;  // Microsecond prescaler
  logic [seq_ctl_pkg::TAG_US_W-1:0] us_left_q, us_left_d; // Microseconds still to run

  // Width is latched at start; rewriting the code mid-pulse has no effect.
  // Requests during a pulse are ignored rather than stretching it.
  always_comb begin
    pulse_d   = pulse_q;
    us_pre_d  = us_pre_q;
    us_left_d = us_left_q;
    if (!pulse_q) begin
      if (tag_request_i) begin
        pulse_d   = 1'b1;
        us_pre_d  = '0;
        us_left_d = tag_width_us(regs_q.tag_pulse_width);
      end
    end else if (us_pre_q == seq_ctl_pkg::US_CNT_W'(seq_ctl_pkg::US_CYCLES - 1)) begin
      us_pre_d  = '0;
      us_left_d = us_left_q - 1'b1;
      if (us_left_q == seq_ctl_pkg::TAG_US_W'(1)) pulse_d = 1'b0;
    end else begin
      us_pre_d = us_pre_q + 1'b1;
    end
  end

  // Pulse registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pulse_q   <= 1'b0;
      us_pre_q  <= '0;
      us_left_q <= '0;
    end else begin
      pulse_q   <= pulse_d;
      us_pre_q  <= us_pre_d;
      us_left_q <= us_left_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------------------
  assign reg_rdata_o                   = rdata_q;
  assign reg_ack_o                     = ack_q;
  assign irq_automask_o                = mask_q;
  assign timeout_busy_o                = busy_q;
  assign sync_tag_pulse_o              = pulse_q;
  assign tag_use_uv_threshold_o        = thr_q;
  assign expected_power_on_order_ch1_o = regs_q.expected_power_on_order_ch1;
  assign expected_power_on_order_ch2_o = regs_q.expected_power_on_order_ch2;

endmodule // sequence_automask_tagging_control

// ### hw/seq_ctl_pkg.sv
// Purpose : Shared constants and carriers of the sequence auto-mask and tagging control bank
// Assumes : 100 MHz core clock, 8 monitored channels, 8-bit register interface
// Notes   : Every offset, reset value and cycle count lives here once
package seq_ctl_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS = 8;     // Monitored channels, bit N-1 is channel N
  localparam int unsigned ADDR_W       = 8;     // Register address width
  localparam int unsigned DATA_W       = 8;     // Register data width

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_AUTOMASK_POWER_ON    = 8'hA1;
  localparam logic [7:0] OFS_AUTOMASK_POWER_OFF   = 8'hA2;
  localparam logic [7:0] OFS_AUTOMASK_SLEEP_EXIT  = 8'hA3;
  localparam logic [7:0] OFS_AUTOMASK_SLEEP_ENTRY = 8'hA4;
  localparam logic [7:0] OFS_TIMEOUT_HIGH         = 8'hA5;
  localparam logic [7:0] OFS_TIMEOUT_LOW          = 8'hA6;
  localparam logic [7:0] OFS_TAG_PULSE_WIDTH      = 8'hA7;
  localparam logic [7:0] OFS_UP_TAG_THRESHOLD     = 8'hA8;
  localparam logic [7:0] OFS_DOWN_TAG_THRESHOLD   = 8'hA9;
  localparam logic [7:0] OFS_EXPECTED_ORDER_CH1   = 8'hB0;
  localparam logic [7:0] OFS_EXPECTED_ORDER_CH2   = 8'hB1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_AUTOMASK       = 8'hFF;  // All four auto-mask registers
  localparam logic [7:0] RST_TIMEOUT        = 8'h00;
  localparam logic [7:0] RST_TAG_PULSE      = 8'h00;
  localparam logic [7:0] RST_UP_TAG_THRESH  = 8'h1F;
  localparam logic [7:0] RST_DOWN_TAG_THRESH = 8'h00;
  localparam logic [7:0] RST_EXPECTED_ORDER = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED     = 8'h00;  // Answer to an unmapped address

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;                          // 100 MHz
  localparam int unsigned US_NS         = 1000;                        // One microsecond
  localparam int unsigned MS_NS         = 1000000;                     // One millisecond
  localparam int unsigned US_CYCLES     = US_NS / CLK_PERIOD_NS;       // 100 cycles
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;       // 100000 cycles
  localparam int unsigned TAG_BASE_US   = 50;                          // Width at code zero
  localparam int unsigned TAG_STEP_US   = 10;                          // Width per code step
  localparam int unsigned US_CNT_W      = 7;                           // Holds US_CYCLES-1
  localparam int unsigned MS_PRE_W      = 17;                          // Holds MS_CYCLES_DEF-1
  localparam int unsigned TAG_US_W      = 12;                          // Holds 2600

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              write;   // One-cycle write strobe
    logic              read;    // One-cycle read strobe
    logic [ADDR_W-1:0] addr;    // Register offset
    logic [DATA_W-1:0] wdata;   // Write data
  } reg_req_t;

  typedef struct packed {
    logic [7:0] automask_power_on;
    logic [7:0] automask_power_off;
    logic [7:0] automask_sleep_exit;
    logic [7:0] automask_sleep_entry;
    logic [7:0] transition_timeout_high;
    logic [7:0] transition_timeout_low;
    logic [7:0] tag_pulse_width;
    logic [7:0] up_tag_threshold_select;
    logic [7:0] down_tag_threshold_select;
    logic [7:0] expected_power_on_order_ch1;
    logic [7:0] expected_power_on_order_ch2;
  } ctl_regs_t;

endpackage

// ### hw/sync_edge_detect.sv
// Purpose : Three-stage pin synchroniser with agreement filter and edge pulses
// Assumes : Input is asynchronous to core_clk_i
// Notes   : A change counts only once stages two and three agree
`timescale 1ns/1ps
module sync_edge_detect (
  input  wire logic core_clk_i,   // Core clock
  input  wire logic sys_rst_i,    // Synchronous reset, active high
  input  wire logic pin_i,        // Raw asynchronous level
  output logic      level_o,      // Filtered level
  output logic      rise_o,       // One-cycle pulse on filtered rise
  output logic      fall_o        // One-cycle pulse on filtered fall
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic stage1_q, stage2_q, stage3_q;   // Synchroniser chain
  logic level_q,  level_d;              // Accepted level
  logic rise_q,   rise_d;
  logic fall_q,   fall_d;

  // Next values: stage one is seen only by stage two
  always_comb begin
    level_d = level_q;
    rise_d  = 1'b0;
    fall_d  = 1'b0;
    if (stage2_q == stage3_q && stage3_q != level_q) begin
      level_d = stage3_q;
      rise_d  = stage3_q;
      fall_d  = ~stage3_q;
    end
  end

  // Registers; reset level is low so a high pin at reset gives one rise
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_q  <= 1'b0;
      rise_q   <= 1'b0;
      fall_q   <= 1'b0;
    end else begin
      stage1_q <= pin_i;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= level_d;
      rise_q   <= rise_d;
      fall_q   <= fall_d;
    end
  end

  assign level_o = level_q;
  assign rise_o  = rise_q;
  assign fall_o  = fall_q;

endmodule // sync_edge_detect

// ### tb/host_model.sv
// Purpose: Host side of the register interface, one transfer per call
// Assumes: Strobes are one-cycle pulses, answer one cycle after the taking edge
// Notes: Released request lines go back to zero
`timescale 1ns/1ps
module host_model (
  input  wire logic             core_clk_i,  // Core clock
  input  wire logic [7:0]       reg_rdata_i, // Read data from the bank
  input  wire logic             reg_ack_i,   // Answer pulse
  output seq_ctl_pkg::reg_req_t reg_req_o    // Request to the bank
);
  initial reg_req_o = '0;
  // Strobe for one cycle only, since a held strobe would be a second request
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge core_clk_i);
    reg_req_o <= {wr, ~wr, a, d};
    @(posedge core_clk_i);
    reg_req_o <= '0;
    @(posedge core_clk_i);
    ok = reg_ack_i;
    q = reg_rdata_i;
  endtask
endmodule // host_model

// ### tb/seq_ctl_checker.sv
// Purpose: Port assertions of the sequence control bank
// Assumes: MS_CYCLES of at least 8
// Notes: Attached by bind at the foot
`timescale 1ns/1ps
module seq_ctl_checker #(parameter int unsigned MS_CYCLES = 10) (
  input wire logic                  core_clk_i,
  input wire logic                  sys_rst_i,
  input wire seq_ctl_pkg::reg_req_t reg_req_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  reg_ack_o,
  input wire logic                  power_active_input_i,
  input wire logic                  tag_request_i,
  input wire logic [7:0]            irq_automask_o,
  input wire logic                  timeout_busy_o,
  input wire logic                  sync_tag_pulse_o,
  input wire logic [7:0]            expected_power_on_order_ch1_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  ack_follows_a: assert property ((reg_req_i.write || reg_req_i.read) |=> reg_ack_o) else $error("ack missing");
  ack_cause_a: assert property (reg_ack_o |-> $past(reg_req_i.write || reg_req_i.read)) else $error("stray ack");
  unmapped_zero_a: assert property (reg_req_i.read && reg_req_i.addr == 8'hC0
    |=> reg_rdata_o == seq_ctl_pkg::RDATA_UNMAPPED) else $error("unmapped data");
  order_store_a: assert property (reg_req_i.write && reg_req_i.addr == seq_ctl_pkg::OFS_EXPECTED_ORDER_CH1
    |=> ##1 expected_power_on_order_ch1_o == $past(reg_req_i.wdata, 2)) else $error("order lost");
  tag_start_a: assert property (tag_request_i && !sync_tag_pulse_o |=> sync_tag_pulse_o) else $error("no pulse");
  tag_hold_a: assert property ($rose(sync_tag_pulse_o) |-> sync_tag_pulse_o[*8]) else $error("pulse short");
  act_window_a: assert property ($rose(power_active_input_i) |-> ##[3:7] timeout_busy_o) else $error("late");
  mask_in_window_a: assert property (irq_automask_o != 8'h00 |-> timeout_busy_o) else $error("mask idle");
  mask_release_a: assert property ($fell(timeout_busy_o) |-> irq_automask_o == 8'h00) else $error("kept");
  window_min_a: assert property ($rose(timeout_busy_o) |-> timeout_busy_o[*8]) else $error("window short");
endmodule // seq_ctl_checker
bind sequence_automask_tagging_control seq_ctl_checker #(.MS_CYCLES(MS_CYCLES)) i_seq_ctl_checker (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .reg_ack_o(reg_ack_o), .power_active_input_i(power_active_input_i), .tag_request_i(tag_request_i),
  .irq_automask_o(irq_automask_o), .timeout_busy_o(timeout_busy_o), .sync_tag_pulse_o(sync_tag_pulse_o),
  .expected_power_on_order_ch1_o(expected_power_on_order_ch1_o));

// ### tb/tb_top.sv
// Purpose: Register and transition tests of the sequence control bank
// Assumes: Millisecond shortened to 10 cycles
// Notes: Pins change at the clock edge, so sync latency is fixed
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned MS = 10;
  logic clk = 1'b0, rst = 1'b1, act = 1'b0, slp = 1'b0, treq = 1'b0, ack, busy, pulse, ok;
  logic [7:0] rdata, mask, thr, o1, o2, q;
  seq_ctl_pkg::reg_req_t req;
  int n_mismatch = 0, samples_checked = 0, n, i;
  logic [7:0] adr[11] = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hB0, 8'hB1};
  logic [7:0] rv[11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00};
  logic [7:0] pat[11] = '{8'h81, 8'h3C, 8'h5A, 8'hA5, 8'h00, 8'h02, 8'h01, 8'h33, 8'hCC, 8'h7E, 8'h42};
  initial forever #5 clk = ~clk;
  host_model i_host_model (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_req_o(req));
  sequence_automask_tagging_control #(.MS_CYCLES(MS)) i_sequence_automask_tagging_control (
    .core_clk_i(clk), .sys_rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .power_active_input_i(act), .sleep_input_i(slp), .tag_request_i(treq), .irq_automask_o(mask),
    .timeout_busy_o(busy), .sync_tag_pulse_o(pulse), .tag_use_uv_threshold_o(thr),
    .expected_power_on_order_ch1_o(o1), .expected_power_on_order_ch2_o(o2));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.xfer(1'b1, a, d, q, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_host_model.xfer(1'b0, a, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h01);
    chk(q, e);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Toggle one pin, then check mask, threshold choice and window length
  task automatic trans(input int p, input logic [7:0] m, input logic [7:0] th, input logic [15:0] c);
    wr(8'hA5, c[15:8]);
    wr(8'hA6, c[7:0]);
    @(posedge clk);
    if (p == 0) act <= ~act;
    else slp <= ~slp;
    i = 0;
    while (busy !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (i == 20) begin
      n_mismatch++;
      summarize();
    end
    @(posedge clk);
    chk(mask, m);
    chk(thr, th);
    n = 2;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n == 5000) begin
      n_mismatch++;
      summarize();
    end
    chk({7'h00, n >= (c + 1) * MS - 1 && n <= (c + 1) * MS + 3}, 8'h01);
    chk(mask, 8'h00);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk(thr, 8'h1F);
    chk(mask, 8'h00);
    for (int k = 0; k < 11; k++) rd(adr[k], rv[k]);
    for (int k = 0; k < 11; k++) begin
      wr(adr[k], pat[k]);
      rd(adr[k], pat[k]);
    end
    chk(o1, 8'h7E);
    chk(o2, 8'h42);
    rd(8'hC0, seq_ctl_pkg::RDATA_UNMAPPED);
    trans(0, 8'h81, 8'h33, 16'h0002);
    trans(0, 8'h3C, 8'hCC, 16'h0100);
    trans(1, 8'h5A, 8'h33, 16'h0000);
    trans(1, 8'hA5, 8'hCC, 16'h0001);
    @(posedge clk);
    treq <= 1'b1;
    @(posedge clk);
    treq <= 1'b0;
    n = 0;
    repeat (6100) begin
      @(posedge clk);
      n += (pulse === 1'b1);
    end
    chk({7'h00, n == 6000}, 8'h01);
    summarize();
  end
endmodule // tb_top
